/* File: gated_sixteen_bit_timer.v */
// gated 16-bit timer/counter with prescaler, capture/compare base and apb registers
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"

module gated_sixteen_bit_timer
(
   input wire clock_i,
   input wire rst_n_i,
   input wire psel_i,
   input wire penable_i,
   input wire pwrite_i,
   input wire [7:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [3:0] pstrb_i,
   output reg [31:0] prdata_o,
   output reg pready_o,
   output reg pslverr_o,
   input wire ext_clock_pin_i,
   input wire gate_pin_i,
   input wire second_comparator_output_i,
   input wire capture_pin_i,
   input wire sleep_i,
   output reg irq_o,
   output reg wake_o,
   output reg special_trigger_o,
   output reg timer_tick_o,
   output reg comparator_synced_o,
   output reg [15:0] count_o
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   reg [15:0] count;
   reg [`CTL_WIDTH-1:0] timer_control_reg;
   reg [`ST_WIDTH-1:0] peripheral_request_reg;
   reg [`ST_WIDTH-1:0] peripheral_enable_reg;
   reg [1:0] core_irq_control_reg;
   reg [15:0] capcomp;
   reg [2:0] capcomp_mode;
   reg [6:0] prescale_count;
   reg [1:0] instr_div;
   reg ext_clock_q;
   reg capture_q;
   reg match_q;
   reg comp_held;

   wire ext_clock_s;
   wire gate_pin_s;
   wire comp_s;
   wire capture_s;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   sync_two_stage sync_ext
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(ext_clock_pin_i),
      .sync_o(ext_clock_s)
   );

   sync_two_stage sync_gate
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(gate_pin_i),
      .sync_o(gate_pin_s)
   );

   sync_two_stage sync_comp
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(second_comparator_output_i),
      .sync_o(comp_s)
   );

   sync_two_stage sync_capture
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .async_i(capture_pin_i),
      .sync_o(capture_s)
   );

   // ------------------------------------------------------------
   // control field decode
   // ------------------------------------------------------------
   wire timer_on = timer_control_reg[`CTL_TIMER_ON];
   wire clock_source_select = timer_control_reg[`CTL_CLOCK_SOURCE];
   wire sync_disable = timer_control_reg[`CTL_SYNC_DISABLE];
   wire alt_clock_select = timer_control_reg[`CTL_ALT_CLOCK];
   wire gate_enable = timer_control_reg[`CTL_GATE_ENABLE];
   wire gate_invert = timer_control_reg[`CTL_GATE_INVERT];
   wire gate_from_comp = timer_control_reg[`CTL_GATE_FROM_COMP];
   wire comp_sync_enable = timer_control_reg[`CTL_COMP_SYNC];
   wire [2:0] prescale_sel = timer_control_reg[`CTL_PRESCALE_HI:`CTL_PRESCALE_LO];
   wire overflow_irq_enable = peripheral_enable_reg[`ST_OVERFLOW];
   wire global_irq_enable = core_irq_control_reg[`CORE_GLOBAL_EN];
   wire peripheral_irq_enable = core_irq_control_reg[`CORE_PERIPH_EN];
   wire [1:0] cc_mode = capcomp_mode[1:0];

   // ------------------------------------------------------------
   // apb access decode
   // ------------------------------------------------------------
   wire access = psel_i & penable_i & pready_o;
   wire wr = access & pwrite_i;
   wire wr_lane0 = wr & pstrb_i[0];
   wire wr_count_lo = wr_lane0 && (paddr_i == `ADDR_COUNT_LOW);
   wire wr_count_hi = wr_lane0 && (paddr_i == `ADDR_COUNT_HIGH);
   wire wr_count = wr_count_lo | wr_count_hi;
   wire wr_status = wr_lane0 && (paddr_i == `ADDR_PERIPH_REQUEST);

   // ------------------------------------------------------------
   // count clock selection and prescaler
   // ------------------------------------------------------------
   // in a sleeping core only the asynchronous external counter keeps going
   wire async_ext = clock_source_select & sync_disable;
   wire run_ok = timer_on & (~sleep_i | async_ext);
   wire ext_rise = ext_clock_s & ~ext_clock_q;
   wire div_tick = (instr_div == `INSTR_DIV_LAST);
   reg src_tick;

   always @*
   begin
      if (clock_source_select)
         src_tick = ext_rise;
      else if (alt_clock_select)
         src_tick = 1'b1;
      else
         src_tick = div_tick;
   end

   // gate is active low at the pin side: with no inversion, count while it is low
   wire gate_raw = gate_from_comp ? comp_held : gate_pin_s;
   wire gate_open = ~gate_enable | (gate_raw == gate_invert);

   wire [6:0] prescale_mask = 7'h7f >> (3'd7 - prescale_sel);
   wire src_step = src_tick & run_ok & gate_open;
   wire prescale_done = ((prescale_count & prescale_mask) == prescale_mask);
   wire inc = src_step & prescale_done;
   wire overflow = inc && (count == `COUNT_MAX);

   // ------------------------------------------------------------
   // capture / compare
   // ------------------------------------------------------------
   wire is_compare = (cc_mode == `CCM_COMPARE) || (cc_mode == `CCM_COMPARE_TRIG);
   wire match = is_compare && (count == capcomp);
   wire match_rise = match & ~match_q;
   wire special_clear = (cc_mode == `CCM_COMPARE_TRIG) & match_rise;
   wire capture_edge = capcomp_mode[`CCM_FALLING] ? (capture_q & ~capture_s) :
                       (~capture_q & capture_s);
   wire capture_hit = (cc_mode == `CCM_CAPTURE) & capture_edge;

   // ------------------------------------------------------------
   // next count
   // ------------------------------------------------------------
   reg [15:0] next_count;

   always @*
   begin
      next_count = count;
      if (wr_count)
      begin
         // a byte write beats a coincident special trigger
         if (wr_count_hi)
            next_count[15:8] = pwdata_i[7:0];
         if (wr_count_lo)
            next_count[7:0] = pwdata_i[7:0];
      end
      else if (special_clear)
         next_count = 16'h0000;
      else if (inc)
         next_count = count + 16'h0001;
   end

   // ------------------------------------------------------------
   // next status: hardware set wins over write-one-to-clear
   // ------------------------------------------------------------
   reg [`ST_WIDTH-1:0] next_status;
   reg [`ST_WIDTH-1:0] set_bits;

   always @*
   begin
      set_bits = {`ST_WIDTH{1'b0}};
      set_bits[`ST_OVERFLOW] = overflow;
      set_bits[`ST_COMPARE] = match_rise;
      set_bits[`ST_CAPTURE] = capture_hit;
      next_status = peripheral_request_reg;
      if (wr_status)
         next_status = next_status & ~pwdata_i[`ST_WIDTH-1:0];
      next_status = next_status | set_bits;
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   reg [31:0] read_value;
   reg read_ok;

   always @*
   begin
      read_value = 32'h0000_0000;
      read_ok = 1'b1;
      if (paddr_i == `ADDR_COUNT_LOW)
         read_value[7:0] = count[7:0];
      else if (paddr_i == `ADDR_COUNT_HIGH)
         read_value[7:0] = count[15:8];
      else if (paddr_i == `ADDR_TIMER_CONTROL)
         read_value[`CTL_WIDTH-1:0] = timer_control_reg;
      else if (paddr_i == `ADDR_PERIPH_REQUEST)
         read_value[`ST_WIDTH-1:0] = peripheral_request_reg;
      else if (paddr_i == `ADDR_PERIPH_ENABLE)
         read_value[`ST_WIDTH-1:0] = peripheral_enable_reg;
      else if (paddr_i == `ADDR_CORE_IRQ_CONTROL)
         read_value[1:0] = core_irq_control_reg;
      else if (paddr_i == `ADDR_CAPCOMP_LOW)
         read_value[7:0] = capcomp[7:0];
      else if (paddr_i == `ADDR_CAPCOMP_HIGH)
         read_value[7:0] = capcomp[15:8];
      else if (paddr_i == `ADDR_CAPCOMP_MODE)
         read_value[2:0] = capcomp_mode;
      else
         read_ok = 1'b0;
   end

   // ------------------------------------------------------------
   // apb slave: one wait-free access phase, answer prepared in setup
   // ------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
      end
      else
      begin
         pready_o <= psel_i & ~penable_i;
         if (psel_i & ~penable_i)
         begin
            pslverr_o <= ~read_ok;
            prdata_o <= pwrite_i ? 32'h0000_0000 : read_value;
         end
         else
         begin
            pslverr_o <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         timer_control_reg <= `RST_CONTROL;
         peripheral_enable_reg <= {`ST_WIDTH{1'b0}};
         core_irq_control_reg <= 2'b00;
         capcomp_mode <= 3'b000;
      end
      else if (wr_lane0)
      begin
         if (paddr_i == `ADDR_TIMER_CONTROL)
            timer_control_reg <= pwdata_i[`CTL_WIDTH-1:0];
         else if (paddr_i == `ADDR_PERIPH_ENABLE)
            peripheral_enable_reg <= pwdata_i[`ST_WIDTH-1:0];
         else if (paddr_i == `ADDR_CORE_IRQ_CONTROL)
            core_irq_control_reg <= pwdata_i[1:0];
         else if (paddr_i == `ADDR_CAPCOMP_MODE)
            capcomp_mode <= pwdata_i[2:0];
      end
   end

   // capture beats a coincident software write to the pair
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         capcomp <= 16'h0000;
      else if (capture_hit)
         capcomp <= count;
      else if (wr_lane0 && (paddr_i == `ADDR_CAPCOMP_LOW))
         capcomp[7:0] <= pwdata_i[7:0];
      else if (wr_lane0 && (paddr_i == `ADDR_CAPCOMP_HIGH))
         capcomp[15:8] <= pwdata_i[7:0];
   end

   // ------------------------------------------------------------
   // counting core
   // ------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count <= `RST_COUNT;
         prescale_count <= 7'h00;
         instr_div <= 2'h0;
         ext_clock_q <= 1'b0;
         capture_q <= 1'b0;
         match_q <= 1'b0;
         comp_held <= 1'b0;
         peripheral_request_reg <= {`ST_WIDTH{1'b0}};
      end
      else
      begin
         count <= next_count;
         peripheral_request_reg <= next_status;
         instr_div <= instr_div + 2'h1;
         ext_clock_q <= ext_clock_s;
         capture_q <= capture_s;
         match_q <= match;
         // a count write restarts the prescaler so the next increment is a full period
         if (wr_count)
            prescale_count <= 7'h00;
         else if (src_step)
            prescale_count <= prescale_done ? 7'h00 : prescale_count + 7'h01;
         // sampling on increments keeps the gate steady between two counts
         if (!comp_sync_enable)
            comp_held <= comp_s;
         else if (inc)
            comp_held <= comp_s;
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
         special_trigger_o <= 1'b0;
         timer_tick_o <= 1'b0;
         comparator_synced_o <= 1'b0;
         count_o <= `RST_COUNT;
      end
      else
      begin
         irq_o <= global_irq_enable & peripheral_irq_enable &
                  (|(next_status & peripheral_enable_reg));
         wake_o <= sleep_i & timer_on & overflow_irq_enable & peripheral_irq_enable &
                   next_status[`ST_OVERFLOW];
         special_trigger_o <= special_clear;
         timer_tick_o <= inc;
         comparator_synced_o <= comp_held;
         count_o <= next_count;
      end
   end

endmodule

`default_nettype wire

/* File: timer_map.vh */
// register map, field positions, reset values and timing counts of the gated 16-bit timer
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define ADDR_COUNT_LOW 8'h00
`define ADDR_COUNT_HIGH 8'h04
`define ADDR_TIMER_CONTROL 8'h08
`define ADDR_PERIPH_REQUEST 8'h0c
`define ADDR_PERIPH_ENABLE 8'h10
`define ADDR_CORE_IRQ_CONTROL 8'h14
`define ADDR_CAPCOMP_LOW 8'h18
`define ADDR_CAPCOMP_HIGH 8'h1c
`define ADDR_CAPCOMP_MODE 8'h20

// ------------------------------------------------------------
// timer_control_reg fields
// ------------------------------------------------------------
`define CTL_TIMER_ON 0
`define CTL_CLOCK_SOURCE 1
`define CTL_SYNC_DISABLE 2
`define CTL_LP_OSC_ENABLE 3
`define CTL_PRESCALE_LO 4
`define CTL_PRESCALE_HI 6
`define CTL_GATE_ENABLE 7
`define CTL_GATE_INVERT 8
`define CTL_ALT_CLOCK 9
`define CTL_GATE_FROM_COMP 10
`define CTL_COMP_SYNC 11
`define CTL_WIDTH 12

// ------------------------------------------------------------
// status / mask / core control / capture-compare mode fields
// ------------------------------------------------------------
`define ST_OVERFLOW 0
`define ST_COMPARE 1
`define ST_CAPTURE 2
`define ST_WIDTH 3
`define CORE_GLOBAL_EN 0
`define CORE_PERIPH_EN 1
`define CCM_OFF 2'b00
`define CCM_CAPTURE 2'b01
`define CCM_COMPARE 2'b10
`define CCM_COMPARE_TRIG 2'b11
`define CCM_FALLING 2

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define RST_COUNT 16'h0000
`define RST_CONTROL 12'h000
`define COUNT_MAX 16'hffff
`define INSTR_DIV 4
`define INSTR_DIV_LAST 2'h3

`endif

/* File: sync_two_stage.v */
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none

module sync_two_stage
(
   input wire clock_i,
   input wire rst_n_i,
   input wire async_i,
   output reg sync_o
);

   reg stage_one;

   // stage_one feeds nothing but sync_o
   always @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage_one <= 1'b0;
         sync_o <= 1'b0;
      end
      else
      begin
         stage_one <= async_i;
         sync_o <= stage_one;
      end
   end

endmodule

`default_nettype wire

/* File: gated_sixteen_bit_timer_chk.sv */
// assertion checker on the ports of the gated 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
module timer_chk
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sleep_i,
   input wire logic irq_o,
   input wire logic wake_o,
   input wire logic special_trigger_o,
   input wire logic [15:0] count_o
);
   logic take, cw, mask0;
   logic [1:0] core, src;
   // enables and clock source are not ports, so they are mirrored off the bus
   assign take = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && !pslverr_o;
   assign cw = take && paddr_i[7:3] == 5'h00;
   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i)
         {mask0, core, src} <= 5'h00;
      else if (take && paddr_i == `ADDR_PERIPH_ENABLE)
         mask0 <= pwdata_i[`ST_OVERFLOW];
      else if (take && paddr_i == `ADDR_CORE_IRQ_CONTROL)
         core <= pwdata_i[1:0];
      else if (take && paddr_i == `ADDR_TIMER_CONTROL)
         src <= pwdata_i[2:1];
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_ready_once;
      pready_o |=> !pready_o;
   endproperty
   a_ready_once: assert property (p_ready_once) else $error("ready too long");
   property p_ready_cause;
      pready_o |-> $past(psel_i) && !$past(penable_i);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
   property p_err_read;
      pslverr_o && !pwrite_i |-> pready_o && prdata_o == 32'h0;
   endproperty
   a_err_read: assert property (p_err_read) else $error("bad error read");
   property p_count_step;
      !$stable(count_o) |-> count_o == $past(count_o) + 16'h0001 || count_o == 16'h0000
         || $past(cw) || $past(cw, 2);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count jumped");
   property p_ovf_irq;
      $past(count_o) == 16'hffff && count_o == 16'h0000 && !$past(cw) && mask0 && core == 2'b11
         |-> ##[0:2] irq_o;
   endproperty
   a_ovf_irq: assert property (p_ovf_irq) else $error("wrap raised no irq");
   property p_irq_gate;
      irq_o |-> core == 2'b11 || $past(core) == 2'b11;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
   property p_trig_clear;
      special_trigger_o |-> count_o <= 16'h0001 || $past(cw) || $past(cw, 2);
   endproperty
   a_trig_clear: assert property (p_trig_clear) else $error("trigger kept count");
   property p_wake_sleep;
      wake_o |-> $past(sleep_i) && $past(mask0);
   endproperty
   a_wake_sleep: assert property (p_wake_sleep) else $error("wake out of sleep");
   property p_sleep_hold;
      (sleep_i && src != 2'b11) [*4] |-> $stable(count_o) || $past(cw) || count_o == 16'h0000;
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");
endmodule
bind gated_sixteen_bit_timer timer_chk timer_chk_i
(
   .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i,
   .prdata_o, .pready_o, .pslverr_o, .sleep_i, .irq_o, .wake_o, .special_trigger_o, .count_o
);
`default_nettype wire

/* File: timer_far_side.sv */
// far-side pins: external count clock, gate, comparator level and capture event
`timescale 1ns/1ps
`default_nettype none
module timer_far_side
(
   input wire logic clock_i,
   output var logic ext_clock_o,
   output var logic gate_o,
   output var logic comp_o,
   output var logic capture_o
);
   // gate idles high, which is the inactive level of the pin
   initial
      {ext_clock_o, gate_o, comp_o, capture_o} = 4'b0100;
   // levels last several clocks since the pins pass a two-stage synchroniser
   task automatic ext_pulses(input int n, input int half);
      repeat (n)
      begin
         @(posedge clock_i);
         ext_clock_o <= 1'b1;
         repeat (half) @(posedge clock_i);
         ext_clock_o <= 1'b0;
         repeat (half) @(posedge clock_i);
      end
   endtask
   task automatic set_comp(input logic v);
      @(posedge clock_i);
      comp_o <= v;
   endtask
   task automatic capture_pulse();
      @(posedge clock_i);
      capture_o <= 1'b1;
      repeat (4) @(posedge clock_i);
      capture_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: gated_sixteen_bit_timer_tb_top.sv */
// self-checking bench for the gated 16-bit timer
`timescale 1ns/1ps
`default_nettype none
`include "timer_map.vh"
module gated_sixteen_bit_timer_tb_top;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, sleep_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [3:0] pstrb_i = 4'hf;
   logic ext_clock_pin_i, gate_pin_i, second_comparator_output_i, capture_pin_i;
   logic pready_o, pslverr_o, irq_o, wake_o, special_trigger_o, timer_tick_o;
   logic comparator_synced_o;
   logic [15:0] count_o;
   logic [31:0] prdata_o, d;
   logic [31:0] seed = 32'd42;
   logic [33:0] note;
   logic [33:0] notes[$];
   int n_errors = 0, tests_run = 0, n, p;
   gated_sixteen_bit_timer gated_sixteen_bit_timer_i (.*);
   timer_far_side timer_far_side_i
   (
      .clock_i, .ext_clock_o(ext_clock_pin_i), .gate_o(gate_pin_i),
      .comp_o(second_comparator_output_i), .capture_o(capture_pin_i)
   );
   always #2 clock_i = ~clock_i;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      tests_run++;
      if (got !== want)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, want);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // note layout: read flag, expected error, expected data
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
      input logic [32:0] e);
      int k;
      notes.push_back({~w, e});
      @(posedge clock_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, v};
      @(posedge clock_i);
      penable_i <= 1'b1;
      k = 0;
      // pready_o is looked at on the rising edge itself, before that edge updates it
      do
      begin
         @(posedge clock_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 40);
      if (k >= 40)
         check(32'h0, 32'h1);
      {psel_i, penable_i} <= 2'b00;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v, 33'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      xfer(1'b0, a, 32'h0, {1'b0, want});
   endtask
   // count for a fixed window; on/off latency and divider phase allow two counts of slack
   task automatic run(input logic [11:0] ctl, input int want);
      wr(`ADDR_COUNT_LOW, 32'h0);
      wr(`ADDR_COUNT_HIGH, 32'h0);
      wr(`ADDR_TIMER_CONTROL, {20'h0, ctl});
      repeat (1024) @(posedge clock_i);
      wr(`ADDR_TIMER_CONTROL, 32'h0);
      @(negedge clock_i);
      check((count_o + 2 >= want && count_o <= want + 2) ? want : count_o, want);
   endtask
   always @(posedge clock_i)
      if (psel_i && penable_i && pready_o === 1'b1)
      begin
         note = notes.pop_front();
         check({31'h0, pslverr_o}, {31'h0, note[32]});
         if (note[33])
            check(prdata_o, note[31:0]);
      end
   initial
   begin
      #100000;
      n_errors++;
      conclude();
   end
   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int a = 0; a <= 32; a += 4)
         rd(a[7:0], 32'h0);
      xfer(1'b1, 8'h24, 32'h1, {1'b1, 32'h0});
      xfer(1'b0, 8'h24, 32'h0, {1'b1, 32'h0});
      d = rnd();
      wr(`ADDR_COUNT_LOW, d);
      wr(`ADDR_COUNT_HIGH, d >> 8);
      rd(`ADDR_COUNT_LOW, {24'h0, d[7:0]});
      rd(`ADDR_COUNT_HIGH, {24'h0, d[15:8]});
      $display("register test done");
      for (int i = 0; i < 4; i++)
      begin
         p = (i < 2) ? 0 : rnd() % 8;
         run({2'b00, i[0], 2'b00, p[2:0], 4'h1}, 1027 / ((i[0] ? 1 : 4) << p));
      end
      for (int i = 0; i < 4; i++)
         run({3'b001, i[1], i[0], 7'h01}, (i == 1) ? 0 : 1027);
      // comparator as gate source: high level closes it, inverted it opens it
      timer_far_side_i.set_comp(1'b1);
      run(12'h681, 0);
      check({31'h0, comparator_synced_o}, 32'h1);
      run(12'h781, 1027);
      timer_far_side_i.set_comp(1'b0);
      wr(`ADDR_COUNT_LOW, 32'h0);
      wr(`ADDR_COUNT_HIGH, 32'h0);
      wr(`ADDR_TIMER_CONTROL, 32'h203);
      n = rnd() % 20 + 1;
      timer_far_side_i.ext_pulses(n, 3);
      repeat (8) @(negedge clock_i);
      check({16'h0, count_o}, n);
      $display("clock and gate test done");
      wr(`ADDR_PERIPH_REQUEST, 32'h7);
      wr(`ADDR_PERIPH_ENABLE, 32'h1);
      wr(`ADDR_CORE_IRQ_CONTROL, 32'h1);
      wr(`ADDR_COUNT_LOW, 32'hf0);
      wr(`ADDR_COUNT_HIGH, 32'hff);
      wr(`ADDR_TIMER_CONTROL, 32'h201);
      repeat (40) @(posedge clock_i);
      @(negedge clock_i);
      check({31'h0, timer_tick_o}, 32'h1);
      wr(`ADDR_TIMER_CONTROL, 32'h0);
      rd(`ADDR_PERIPH_REQUEST, 32'h1);
      check({31'h0, irq_o}, 32'h0);
      wr(`ADDR_CORE_IRQ_CONTROL, 32'h3);
      repeat (3) @(negedge clock_i);
      check({31'h0, irq_o}, 32'h1);
      wr(`ADDR_PERIPH_REQUEST, 32'h1);
      repeat (3) @(negedge clock_i);
      check({31'h0, irq_o}, 32'h0);
      $display("overflow test done");
      wr(`ADDR_COUNT_LOW, 32'h0);
      wr(`ADDR_COUNT_HIGH, 32'h0);
      wr(`ADDR_CAPCOMP_LOW, 32'h10);
      wr(`ADDR_CAPCOMP_MODE, {30'h0, `CCM_COMPARE_TRIG});
      wr(`ADDR_TIMER_CONTROL, 32'h201);
      repeat (200) @(posedge clock_i);
      wr(`ADDR_TIMER_CONTROL, 32'h0);
      check({31'h0, count_o <= 16'h0010}, 32'h1);
      rd(`ADDR_PERIPH_REQUEST, 32'h2);
      wr(`ADDR_PERIPH_REQUEST, 32'h7);
      wr(`ADDR_CAPCOMP_MODE, {30'h0, `CCM_CAPTURE});
      d = rnd();
      wr(`ADDR_COUNT_LOW, d);
      wr(`ADDR_COUNT_HIGH, d >> 8);
      timer_far_side_i.capture_pulse();
      repeat (6) @(posedge clock_i);
      rd(`ADDR_CAPCOMP_LOW, {24'h0, d[7:0]});
      rd(`ADDR_CAPCOMP_HIGH, {24'h0, d[15:8]});
      rd(`ADDR_PERIPH_REQUEST, 32'h4);
      wr(`ADDR_PERIPH_REQUEST, 32'h7);
      wr(`ADDR_CAPCOMP_MODE, 32'h0);
      $display("capture compare test done");
      sleep_i <= 1'b1;
      run(12'h201, 0);
      wr(`ADDR_COUNT_LOW, 32'hfe);
      wr(`ADDR_COUNT_HIGH, 32'hff);
      wr(`ADDR_TIMER_CONTROL, 32'h007);
      timer_far_side_i.ext_pulses(3, 3);
      repeat (8) @(negedge clock_i);
      check({16'h0, count_o}, 32'h1);
      check({30'h0, wake_o, irq_o}, 32'h3);
      @(posedge clock_i);
      sleep_i <= 1'b0;
      $display("sleep test done");
      conclude();
   end
endmodule
`default_nettype wire
